//--- verilog/tenbase_pkg.sv
// Shared constants and state types for the 10 Mb/s Manchester line codec.
// Assumes a 250 MHz system clock and a 20 MHz half-bit line clock.
package tenbase_pkg;

  // Widths of the MII nibble and the counters.
  localparam int NIB_W  = 4;
  localparam int BCNT_W = 6;
  localparam int NCNT_W = 7;
  localparam int NLP_W  = 22;

  // Clock rate and printed times.
  localparam int unsigned SYS_CLK_MHZ   = 250;
  localparam int unsigned BIT_TIME_NS   = 100;
  localparam int unsigned NLP_PERIOD_MS = 16;

  // Cycle counts derived from the times above.
  localparam int unsigned BIT_CYC        = BIT_TIME_NS * SYS_CLK_MHZ / 1000;
  localparam int unsigned NLP_PERIOD_CYC = NLP_PERIOD_MS * 1000 * SYS_CLK_MHZ;
  localparam logic [BCNT_W-1:0] HALF_BIT_START = BCNT_W'(BIT_CYC / 2);
  localparam logic [BCNT_W-1:0] MID_WIN_CYC    = BCNT_W'(BIT_CYC * 3 / 4);
  localparam logic [BCNT_W-1:0] LOSS_CYC       = BCNT_W'(BIT_CYC * 3 / 2);
  localparam logic [NCNT_W-1:0] NIB_CLK_CYC    = NCNT_W'(4 * BIT_CYC);
  localparam logic [NCNT_W-1:0] NIB_CLK_HALF   = NCNT_W'(2 * BIT_CYC);

  // Line clock counts, in half-bit periods.
  localparam logic [2:0] HALVES_LAST = 3'h7;
  localparam logic [2:0] IDL_HALVES  = 3'h6;
  localparam logic [2:0] NLP_HALVES  = 3'h2;

  // Values seen on the MII and after reset.
  localparam logic [NIB_W-1:0] SFD_HI_NIB  = 4'hD;
  localparam logic             MII10_RESET = 1'h1;

  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA, RX_DRAIN} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_IDL, TX_NLP} tx_state_t;

endpackage

//--- verilog/manchester_line_tx.sv
// Transmit side of the codec, run on the 20 MHz half-bit line clock.
// Assumes the MAC drives its transmit nibble on the rising edge of tx_clk_o.
`timescale 1ns/1ns
module manchester_line_tx (
  // Clock and reset
  input  wire logic                         line_clk_i,
  input  wire logic                         srst_i,
  // MAC transmit side
  input  wire logic [tenbase_pkg::NIB_W-1:0] txd_i,
  input  wire logic                         tx_en_i,
  output logic                              tx_clk_o,
  output logic                              tx_busy_o,
  // Link pulse request from the system domain
  input  wire logic                         nlp_toggle_i,
  // Speed selection and 100 Mb/s line levels
  input  wire logic                         speed_100_i,
  input  wire logic                         mlt3_plus_i,
  input  wire logic                         mlt3_minus_i,
  // Transmit pair
  output logic                              pair_tx_plus_o,
  output logic                              pair_tx_minus_o
);
  import tenbase_pkg::*;

  typedef struct packed {
    logic                 rst1, rst2, tg1, tg2, tg3;
    logic                 sp1, sp2, mp1, mp2, mn1, mn2;
    tx_state_t            st;
    logic [2:0]           div;
    logic [2:0]           hcnt;
    logic [NIB_W-1:0]     nib;
    logic                 tx_clk, busy, plus, minus;
  } line_state_t;

  line_state_t s;
  line_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.rst1 = srst_i;
    next_s.rst2 = s.rst1;
    next_s.tg1  = nlp_toggle_i;
    next_s.tg2  = s.tg1;
    next_s.tg3  = s.tg2;
    next_s.sp1  = speed_100_i;
    next_s.sp2  = s.sp1;
    next_s.mp1  = mlt3_plus_i;
    next_s.mp2  = s.mp1;
    next_s.mn1  = mlt3_minus_i;
    next_s.mn2  = s.mn1;
    // Eight half-bits make one nibble, so the 2.5 MHz clock falls out of the divider.
    next_s.div    = s.div + 3'h1; // [RULE_04] [RULE_14]
    next_s.tx_clk = !next_s.div[2]; // [RULE_04]
    next_s.hcnt   = s.hcnt + 3'h1;
    unique case (s.st)
      TX_IDLE, TX_DATA: begin
        if (s.div == HALVES_LAST) begin
          if (tx_en_i && !s.sp2) begin
            next_s.st   = TX_DATA; // [RULE_02]
            next_s.nib  = txd_i;
            next_s.busy = 1'h1;
          end else if (s.st == TX_DATA) begin
            next_s.st   = TX_IDL; // [RULE_12]
            next_s.hcnt = 3'h0;
          end
        end
        // A pulse request that meets a frame is dropped; pulses only fill idle time.
        if (s.st == TX_IDLE && next_s.st == TX_IDLE && (s.tg2 ^ s.tg3) && !s.sp2) begin
          next_s.st   = TX_NLP; // [RULE_07] [RULE_08]
          next_s.hcnt = 3'h0;
        end
      end
      TX_IDL: begin
        if (s.hcnt == IDL_HALVES - 3'h1) begin
          next_s.st   = TX_IDLE;
          next_s.busy = 1'h0;
        end
      end
      TX_NLP: begin
        if (s.hcnt == NLP_HALVES - 3'h1) begin
          next_s.st = TX_IDLE;
        end
      end
    endcase
    if (s.sp2) begin
      next_s.st   = TX_IDLE;
      next_s.busy = 1'h0;
    end
    unique case (next_s.st)
      TX_DATA: begin
        // The first half carries the bit itself, the second its complement.
        next_s.plus  = next_s.nib[next_s.div[2:1]] ^ next_s.div[0]; // [RULE_01] [RULE_13]
        next_s.minus = !next_s.plus;
      end
      TX_IDL, TX_NLP: begin
        next_s.plus  = 1'h1;
        next_s.minus = 1'h0;
      end
      TX_IDLE: begin
        next_s.plus  = 1'h0;
        next_s.minus = 1'h0;
      end
    endcase
    if (s.sp2) begin
      next_s.plus  = s.mp2; // [RULE_10]
      next_s.minus = s.mn2;
    end
    if (s.rst2) begin
      next_s      = '0;
      next_s.st   = TX_IDLE;
      // Parking the divider on its last half-bit makes the first nibble clock high phase full.
      next_s.div  = HALVES_LAST; // [RULE_04]
      next_s.rst1 = srst_i;
      next_s.rst2 = s.rst1;
    end
  end

  always_ff @(posedge line_clk_i) begin
    s <= next_s;
  end

  assign tx_clk_o        = s.tx_clk;
  assign tx_busy_o       = s.busy;
  assign pair_tx_plus_o  = s.plus;
  assign pair_tx_minus_o = s.minus;

  default clocking cb_line @(posedge line_clk_i);
  endclocking
  default disable iff (s.rst2);

  a_nib_clk_rate: assert property ($rose(s.tx_clk) |=> s.tx_clk [*3] ##1 !s.tx_clk [*4]
    ##1 s.tx_clk) else $error("transmit nibble clock is not one eighth of line clock"); // RULE_04
  a_half_split: assert property ((s.st == TX_DATA && s.div[0] && !s.sp2)
    |-> (s.plus != $past(s.plus) && s.minus == !s.plus))
    else $error("second half of a bit does not invert the first"); // RULE_14
  a_nib_lsb_first: assert property ((s.div == HALVES_LAST && tx_en_i && !s.sp2
    && (s.st == TX_IDLE || s.st == TX_DATA))
    |=> (pair_tx_plus_o == $past(txd_i[0])) ##2 (pair_tx_plus_o == $past(txd_i[1], 3)))
    else $error("nibble not sent low bit first with one positive first"); // RULE_13
  a_idl_marker: assert property ((s.st == TX_DATA && !s.sp2) ##1 (s.st == TX_IDL)
    |-> (pair_tx_plus_o && !pair_tx_minus_o) ##[1:6] (s.st == TX_IDLE))
    else $error("end of frame marker missing or too long"); // RULE_12
  a_nlp_not_busy: assert property ((s.st == TX_NLP) |-> (!s.busy && s.plus))
    else $error("link pulse counted as transmission"); // RULE_09
  a_mlt3_pass: assert property (s.sp2 && $past(s.sp2) |-> (s.plus == $past(s.mp2)))
    else $error("100 Mb/s level not passed to the pair"); // RULE_10
  c_idl_sent: cover property ((s.st == TX_IDL) ##6 (s.st == TX_IDLE));

endmodule

//--- verilog/tenbase_t_manchester_codec.sv
// Overview of operation
// [RULE_01] One is positive then negative; zero reversed.
// [RULE_02] Take MAC nibbles, send serial Manchester.
// [RULE_03] Decode received Manchester into NRZ nibbles.
// [RULE_04] Generate 2.5 MHz nibble clock.
// [RULE_05] Lock at preamble, track through reception.
// [RULE_06] Recovered timing paces receive nibbles.
// [RULE_07] Idle link pulse every 16 ms.
// [RULE_08] Keep sending link pulses while receiving.
// [RULE_09] Link pulses never raise collision.
// [RULE_10] Pair carries Manchester or MLT-3 by speed.
// [RULE_11] 10 Mb/s selects nibble MII form.
// [RULE_12] Append end-of-frame marker after last bit.
// [RULE_13] Nibbles go low bit first both ways.
// [RULE_14] Encoder runs at twice the bit rate.
//
// Top of the 10 Mb/s twisted-pair line codec: receive recovery and decode,
// link pulse timing, carrier and collision, and the line-clock transmitter.
// Assumes the receive pair is already sliced to logic levels, both low at idle.
`timescale 1ns/1ns
module tenbase_t_manchester_codec #(
  parameter int unsigned NLP_PERIOD_CYC_P = tenbase_pkg::NLP_PERIOD_CYC
) (
  // System clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          srst_i,
  // Half-bit line clock
  input  wire logic                          line_clk_i,
  // Speed selection
  input  wire logic                          speed_100_i,
  output logic                               mii_10m_o,
  // MII transmit
  input  wire logic [tenbase_pkg::NIB_W-1:0] txd_i,
  input  wire logic                          tx_en_i,
  output logic                               tx_clk_o,
  // MII receive
  output logic [tenbase_pkg::NIB_W-1:0]      rxd_o,
  output logic                               rx_dv_o,
  output logic                               rx_clk_o,
  output logic                               crs_o,
  output logic                               col_o,
  // Receive pair
  input  wire logic                          pair_rx_plus_i,
  input  wire logic                          pair_rx_minus_i,
  // 100 Mb/s levels for the shared pair
  input  wire logic                          mlt3_plus_i,
  input  wire logic                          mlt3_minus_i,
  // Transmit pair
  output logic                               pair_tx_plus_o,
  output logic                               pair_tx_minus_o
);
  import tenbase_pkg::*;

  localparam logic [NLP_W-1:0] NLP_LAST = NLP_W'(NLP_PERIOD_CYC_P - 1);

  typedef struct packed {
    logic                 rxp1, rxp2, rxn1, rxn2;
    logic                 prev_act, prev_pos;
    rx_state_t            st;
    logic [BCNT_W-1:0]    bcnt;
    logic                 last_bit;
    logic [NIB_W-1:0]     nib;
    logic [1:0]           bidx;
    logic [NIB_W-1:0]     rxd;
    logic                 rx_dv;
    logic [NCNT_W-1:0]    ncnt;
    logic                 rx_clk;
    logic                 txb1, txb2, sp1, sp2;
    logic                 mii10, crs, col;
    logic [NLP_W-1:0]     nlp_cnt;
    logic                 nlp_tog;
  } sys_state_t;

  sys_state_t s;
  sys_state_t next_s;
  logic       line_act;
  logic       line_pos;
  logic       mid_edge;
  logic       rx_bit;
  logic       tx_busy;

  // Only the second stage of each pin synchroniser feeds the decoder.
  assign line_act = s.rxp2 ^ s.rxn2;
  assign line_pos = s.rxp2;
  // Transitions near a bit boundary are ignored; only the mid-bit one carries data.
  assign mid_edge = line_act && s.prev_act && (line_pos != s.prev_pos)
                    && (s.bcnt >= MID_WIN_CYC);
  // A fall to negative in mid-bit means a one.
  assign rx_bit   = !line_pos;

  always_comb begin
    next_s          = s;
    next_s.rxp1     = pair_rx_plus_i;
    next_s.rxp2     = s.rxp1;
    next_s.rxn1     = pair_rx_minus_i;
    next_s.rxn2     = s.rxn1;
    next_s.txb1     = tx_busy;
    next_s.txb2     = s.txb1;
    next_s.sp1      = speed_100_i;
    next_s.sp2      = s.sp1;
    next_s.prev_act = line_act;
    next_s.prev_pos = line_pos;
    if (s.bcnt != '1) begin
      next_s.bcnt = s.bcnt + 6'h01;
    end
    // The nibble clock free-runs and is re-phased on every received nibble.
    if (s.ncnt == NIB_CLK_CYC - 7'h01) begin
      next_s.ncnt = '0;
    end else begin
      next_s.ncnt = s.ncnt + 7'h01;
    end

    unique case (s.st)
      RX_IDLE: begin
        if (line_act && line_pos && !s.sp2) begin
          // A preamble opens with a one, so its positive half marks a bit start.
          next_s.st       = RX_HUNT; // [RULE_05]
          next_s.bcnt     = HALF_BIT_START;
          next_s.last_bit = 1'h0;
        end
      end
      RX_HUNT, RX_DATA: begin
        if (!line_act || s.bcnt >= LOSS_CYC) begin
          // Loss of mid-bit transitions ends the frame; the tail is the idle marker.
          next_s.st = (s.st == RX_DATA) ? RX_DRAIN : RX_IDLE;
        end else if (mid_edge) begin
          next_s.bcnt     = '0; // [RULE_05]
          next_s.last_bit = rx_bit;
          if (s.st == RX_HUNT) begin
            // Two ones in a row close the start delimiter and fix nibble alignment.
            if (s.last_bit && rx_bit) begin
              next_s.st    = RX_DATA;
              next_s.rxd   = SFD_HI_NIB;
              next_s.rx_dv = 1'h1;
              next_s.ncnt  = '0; // [RULE_06]
              next_s.bidx  = 2'h0;
            end
          end else begin
            next_s.nib[s.bidx] = rx_bit; // [RULE_03] [RULE_13]
            next_s.bidx        = s.bidx + 2'h1;
            if (s.bidx == 2'h3) begin
              next_s.rxd  = {rx_bit, s.nib[2:0]}; // [RULE_03]
              next_s.ncnt = '0; // [RULE_06]
            end
          end
        end
      end
      RX_DRAIN: begin
        // Hold the last nibble until the MAC has seen one more rising edge.
        if (s.ncnt == NIB_CLK_CYC - 7'h01) begin
          next_s.st    = RX_IDLE;
          next_s.rx_dv = 1'h0;
        end
      end
    endcase

    if (s.sp2) begin
      next_s.st    = RX_IDLE;
      next_s.rx_dv = 1'h0;
    end
    next_s.rx_clk = (next_s.ncnt >= NIB_CLK_HALF); // [RULE_06]

    // The transmitter's busy flag excludes link pulses, so they never collide.
    next_s.crs   = (next_s.st != RX_IDLE) || s.txb2;
    next_s.col   = (next_s.st != RX_IDLE) && s.txb2; // [RULE_09]
    next_s.mii10 = !s.sp2; // [RULE_11]

    // The pulse timer ignores reception so pulses go on during a frame.
    if (s.sp2) begin
      next_s.nlp_cnt = '0;
    end else if (s.nlp_cnt == NLP_LAST) begin
      next_s.nlp_cnt = '0;
      next_s.nlp_tog = !s.nlp_tog; // [RULE_07] [RULE_08]
    end else begin
      next_s.nlp_cnt = s.nlp_cnt + 22'h000001;
    end

    if (srst_i) begin
      next_s       = '0;
      next_s.st    = RX_IDLE;
      next_s.mii10 = MII10_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s <= next_s;
  end

  manchester_line_tx u_line_tx (
    .line_clk_i      (line_clk_i),
    .srst_i          (srst_i),
    .txd_i           (txd_i),
    .tx_en_i         (tx_en_i),
    .tx_clk_o        (tx_clk_o),
    .tx_busy_o       (tx_busy),
    .nlp_toggle_i    (s.nlp_tog),
    .speed_100_i     (speed_100_i),
    .mlt3_plus_i     (mlt3_plus_i),
    .mlt3_minus_i    (mlt3_minus_i),
    .pair_tx_plus_o  (pair_tx_plus_o),
    .pair_tx_minus_o (pair_tx_minus_o)
  );

  assign mii_10m_o = s.mii10;
  assign rxd_o     = s.rxd;
  assign rx_dv_o   = s.rx_dv;
  assign rx_clk_o  = s.rx_clk;
  assign crs_o     = s.crs;
  assign col_o     = s.col;

  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_nlp_period: assert property ($changed(s.nlp_tog)
    |-> ($past(s.nlp_cnt) == NLP_LAST && !$past(s.sp2)))
    else $error("link pulse request off its period"); // RULE_07
  a_nlp_in_rx: assert property ((s.st != RX_IDLE && s.nlp_cnt == NLP_LAST && !s.sp2)
    |=> $changed(s.nlp_tog))
    else $error("link pulse suppressed during reception"); // RULE_08
  a_col_tx_only: assert property (col_o |-> ($past(s.txb2) && $past(tx_busy, 3)))
    else $error("collision without a frame in transmission"); // RULE_09
  a_lock_start: assert property ((s.st == RX_IDLE && line_act && line_pos && !s.sp2)
    |=> (s.st == RX_HUNT && s.bcnt == HALF_BIT_START))
    else $error("recovery did not start on preamble"); // RULE_05
  a_track_loss: assert property ((s.st == RX_DATA && s.bcnt >= LOSS_CYC && !s.sp2)
    |=> (s.st == RX_DRAIN))
    else $error("recovery kept running without transitions"); // RULE_05
  a_rx_pace: assert property ((s.st == RX_DATA && $changed(s.rxd))
    |-> !rx_clk_o ##1 !rx_clk_o [*8])
    else $error("receive nibble not aligned to recovered clock"); // RULE_06
  a_rx_decode: assert property ((s.st == RX_DATA && mid_edge && s.bidx == 2'h3 && !s.sp2
    && s.bcnt < LOSS_CYC) |=> (rxd_o == {!$past(line_pos), $past(s.nib[2:0])}))
    else $error("decoded nibble wrong or out of order"); // RULE_03
  a_mii_mode: assert property ($past(s.sp2, 2) == s.sp2 |-> (mii_10m_o == !s.sp2))
    else $error("MII form does not follow speed"); // RULE_11

  c_rx_frame: cover property ($rose(rx_dv_o) ##[1:400] $changed(rxd_o));
  c_collision: cover property ($rose(col_o));
  c_nlp_rx: cover property ((s.st == RX_DATA) && $changed(s.nlp_tog));

endmodule

//--- verif/mac_mii_model.sv
// Behavioural MAC on the transmit side of the 10 Mb/s nibble MII.
// Assumes the codec samples the nibble on the same line edge that raises tx_clk_o.
`timescale 1ns/1ns
module mac_mii_model (
  // Nibble clock from the codec
  input  wire logic                          tx_clk_i,
  // MII transmit
  output logic [tenbase_pkg::NIB_W-1:0]      txd_o,
  output logic                               tx_en_o
);
  import tenbase_pkg::*;

  initial begin
    txd_o   = 4'h0;
    tx_en_o = 1'b0;
  end

  // Nibbles change just after tx_clk rises, leaving the codec a full period to sample.
  task automatic send(input logic [NIB_W-1:0] nibs[$]);
    foreach (nibs[i]) begin
      @(posedge tx_clk_i);
      #1;
      txd_o   <= nibs[i];
      tx_en_o <= 1'b1;
    end
    @(posedge tx_clk_i);
    #1;
    tx_en_o <= 1'b0;
    // A released bus must not keep showing the last nibble.
    txd_o   <= ~txd_o;
  endtask
endmodule

//--- verif/tenbase_t_manchester_codec_bench.sv
// Self-checking bench for the 10 Mb/s Manchester line codec.
// Assumes the MAC model feeds the transmit MII and the bench drives the receive pair.
`timescale 1ns/1ns
module tenbase_t_manchester_codec_bench;
  import tenbase_pkg::*;

  localparam int unsigned NLP_CYC = 2000;

  logic             sys_clk_i, line_clk_i, srst_i, speed_100_i, mii_10m_o;
  logic [NIB_W-1:0] txd_i, rxd_o;
  logic             tx_en_i, tx_clk_o, rx_dv_o, rx_clk_o, crs_o, col_o;
  logic             pair_rx_plus_i, pair_rx_minus_i, mlt3_plus_i, mlt3_minus_i;
  logic             pair_tx_plus_o, pair_tx_minus_o, in_rx, col_seen;
  logic [NIB_W-1:0] rxq[$];
  int               miscompares, checks, nlp_rx;

  tenbase_t_manchester_codec #(.NLP_PERIOD_CYC_P(NLP_CYC)) tenbase_t_manchester_codec_inst (
    .sys_clk_i, .srst_i, .line_clk_i, .speed_100_i, .mii_10m_o, .txd_i, .tx_en_i, .tx_clk_o,
    .rxd_o, .rx_dv_o, .rx_clk_o, .crs_o, .col_o, .pair_rx_plus_i, .pair_rx_minus_i,
    .mlt3_plus_i, .mlt3_minus_i, .pair_tx_plus_o, .pair_tx_minus_o);
  mac_mii_model mac_mii_model_inst (.tx_clk_i(tx_clk_o), .txd_o(txd_i), .tx_en_o(tx_en_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // The line clock is offset so that its edges never line up with the system clock.
  initial begin
    line_clk_i = 1'b0;
    #13;
    forever #40 line_clk_i = ~line_clk_i;
  end

  always @(posedge rx_clk_o) if (rx_dv_o === 1'b1) rxq.push_back(rxd_o);
  always @(posedge sys_clk_i) if (col_o === 1'b1) col_seen = 1'b1;
  always @(posedge pair_tx_plus_o) if (in_rx) nlp_rx++;

  function automatic logic [1:0] line_half(input logic b, input logic second);
    return (b ^ second) ? 2'b10 : 2'b01;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rx_half(input logic [1:0] lvl, input int cyc);
    {pair_rx_plus_i, pair_rx_minus_i} = lvl;
    repeat (cyc) @(posedge sys_clk_i);
    #1;
  endtask

  // Halves of 12 and 13 cycles give the 25-cycle bit time.
  task automatic rx_bit(input logic b);
    rx_half(line_half(b, 1'b0), 12);
    rx_half(line_half(b, 1'b1), 13);
  endtask

  // Preamble ending in the delimiter, then n random nibbles; on says whether data must appear.
  task automatic rx_run(input int n, input logic on);
    logic [NIB_W-1:0] exp[$];
    logic [NIB_W-1:0] nib;
    exp = {4'hD};
    rxq = {};
    in_rx = 1'b1;
    @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 14; i++) rx_bit(i[0] == 1'b0 || i == 13);
    if (on) check(8'(crs_o), 8'h01, "carrier on preamble");
    repeat (n) begin
      nib = 4'($urandom);
      exp.push_back(nib);
      for (int k = 0; k < NIB_W; k++) rx_bit(nib[k]);
    end
    // A level held with no mid-bit transition must end the frame through the loss timeout.
    rx_half(2'b10, 50);
    rx_half(2'b00, 250);
    in_rx = 1'b0;
    if (!on) exp = {};
    check(8'(rxq.size() < exp.size() || rxq.size() > exp.size() + 1), 8'h00, "rx count");
    foreach (exp[i]) if (i < rxq.size()) check(8'(rxq[i]), 8'(exp[i]), "rx nibble");
    check(8'(rx_dv_o), 8'h00, "rx_dv after frame");
  endtask

  // Starts just after a link pulse so that no pulse can refuse the frame.
  task automatic tx_run(input int n);
    logic [NIB_W-1:0] q[$];
    repeat (n) q.push_back(4'($urandom));
    @(posedge pair_tx_plus_o);
    @(negedge pair_tx_plus_o);
    fork
      mac_mii_model_inst.send(q);
    join_none
    @(posedge tx_clk_o);
    @(posedge tx_clk_o);
    foreach (q[i]) begin
      for (int h = 0; h < 8; h++) begin
        @(negedge line_clk_i);
        check({6'h0, pair_tx_plus_o, pair_tx_minus_o},
              {6'h0, line_half(q[i][h/2], h[0])}, "tx half");
        check(8'(tx_clk_o), 8'(h < 4), "nibble clock");
      end
    end
    repeat (6) begin
      @(negedge line_clk_i);
      check({6'h0, pair_tx_plus_o, pair_tx_minus_o}, 8'h02, "end marker");
    end
    @(negedge line_clk_i);
    check({6'h0, pair_tx_plus_o, pair_tx_minus_o}, 8'h00, "idle after frame");
  endtask

  task automatic nlp_period();
    realtime t0;
    @(posedge pair_tx_plus_o);
    t0 = $realtime;
    for (int i = 0; i < 3; i++) begin
      @(negedge line_clk_i);
      check({6'h0, pair_tx_plus_o, pair_tx_minus_o}, (i < 2) ? 8'h02 : 8'h00, "pulse");
    end
    @(posedge pair_tx_plus_o);
    t0 = $realtime - t0;
    check(8'(t0 > NLP_CYC * 4 - 200 && t0 < NLP_CYC * 4 + 200), 8'h01, "pulse period");
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    {miscompares, checks, nlp_rx, in_rx, col_seen} = '0;
    {srst_i, speed_100_i} = 2'b10;
    {pair_rx_plus_i, pair_rx_minus_i, mlt3_plus_i, mlt3_minus_i} = 4'h0;
    void'($urandom(32'hBB7050CB));
    repeat (10) @(posedge sys_clk_i);
    check({4'h0, rx_dv_o, crs_o, col_o, mii_10m_o}, 8'h01, "reset values");
    // The line domain sees reset through a synchronizer, so it needs line edges too.
    repeat (4) @(posedge line_clk_i);
    @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    nlp_period();
    tx_run(1);
    tx_run(8);
    tx_run(1 + $urandom % 8);
    rx_run(0, 1'b1);
    col_seen = 1'b0;
    rx_run(30, 1'b1);
    check(8'(nlp_rx > 0), 8'h01, "pulses while receiving");
    check(8'(col_seen), 8'h00, "no collision from pulses");
    fork
      tx_run(8);
      begin
        @(posedge crs_o);
        rx_run(1, 1'b1);
      end
    join
    check(8'(col_seen), 8'h01, "collision during frame");
    @(posedge sys_clk_i);
    #1;
    speed_100_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    check(8'(mii_10m_o), 8'h00, "mii form at 100");
    repeat (8) begin
      @(posedge line_clk_i);
      #1;
      {mlt3_plus_i, mlt3_minus_i} = 2'($urandom);
      repeat (6) @(negedge line_clk_i);
      check({6'h0, pair_tx_plus_o, pair_tx_minus_o},
            {6'h0, mlt3_plus_i, mlt3_minus_i}, "mlt3 pass");
    end
    rx_run(2, 1'b0);
    speed_100_i = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    check(8'(mii_10m_o), 8'h01, "mii form at 10");
    tx_run(2);
    close_out();
  end
endmodule
